// ===== hdl/system_address_decoder.sv
// Memory and I/O chip-select decoder with page registers and coprocessor strobes.
// Assumes the bus master is on clk_in and holds address stable while sampled.
`timescale 1ns/1ps
`include "addr_decode_map.svh"
module system_address_decoder #(
  parameter int PAGE_W = 8
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic cycle_valid_in,
  input wire logic mem_cycle_in,
  input wire logic write_in,
  input wire logic [23:0] addr_in,
  input wire logic byte_high_n_in,
  input wire logic protected_mode_in,
  input wire logic dma_cycle_in,
  input wire logic dma_second_in,
  input wire logic [1:0] dma_channel_in,
  input wire logic [7:0] data_in,
  input wire logic strap_upper_ram_in,
  input wire logic colour_mode_in,
  input wire logic exp_ram_fitted_in,
  input wire logic divisor_latch_in,
  output logic base_ram_sel_out,
  output logic exp_ram_sel_out,
  output logic vram_sel_out,
  output logic bios_sel_out,
  output logic [23:0] phys_addr_out,
  output logic io_low_sel_out,
  output logic io_high_sel_out,
  output logic xfer1_sel_out,
  output logic xfer2_sel_out,
  output logic [3:0] xfer_reg_out,
  output logic page_sel_out,
  output logic ser_data_sel_out,
  output logic ser_ier_sel_out,
  output logic ser_div_lo_sel_out,
  output logic ser_div_hi_sel_out,
  output logic coproc_sel_out,
  output logic coproc_busy_clear_out,
  output logic coproc_reset_out
);

  // Straps are board switches outside the clock domain: two stages each
  logic [3:0] strap_s1;
  logic [3:0] strap_s2;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      strap_s1 <= 4'h0;
      strap_s2 <= 4'h0;
    end else begin
      strap_s1 <= {divisor_latch_in, exp_ram_fitted_in, colour_mode_in, strap_upper_ram_in};
      strap_s2 <= strap_s1;
    end
  end
  logic upper_off;
  logic colour;
  logic exp_fitted;
  logic dlab;
  assign upper_off = strap_s2[0];
  assign colour = strap_s2[1];
  assign exp_fitted = strap_s2[2];
  assign dlab = strap_s2[3];

  // Page register file, one entry per transfer channel, written at 008x
  logic [PAGE_W-1:0] page_regs [8];
  logic [2:0] page_idx;
  logic page_hit;
  always_comb begin
    page_hit = 1'b1;
    page_idx = 3'h0;
    case (addr_in[3:0])
      4'h7: page_idx = 3'h0;
      4'h3: page_idx = 3'h1;
      4'h1: page_idx = 3'h2;
      4'h2: page_idx = 3'h3;
      4'hf: page_idx = 3'h4; // Refresh page
      4'hb: page_idx = 3'h5;
      4'h9: page_idx = 3'h6;
      4'ha: page_idx = 3'h7;
      default: page_hit = 1'b0;
    endcase
  end
  logic page_access;
  assign page_access = cycle_valid_in && !mem_cycle_in && !dma_cycle_in
    && addr_in[15:4] == 12'(`IO_PAGE_PAT >> 4) && page_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_page
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          page_regs[gi] <= '0;
        end else if (page_access && write_in && page_idx == 3'(gi)) begin
          page_regs[gi] <= data_in[PAGE_W-1:0];
        end
      end
    end
  endgenerate

  // Physical address: masked in real mode, upper bits from page file on transfers
  logic [23:0] eff_addr;
  always_comb begin
    eff_addr = protected_mode_in ? addr_in : (addr_in & `REAL_MASK); // [R03]
    if (dma_cycle_in) begin
      if (dma_second_in) begin // [R15] [R16] word channels shift by one
        eff_addr = {page_regs[{1'b1, dma_channel_in}][7:1], addr_in[15:0], 1'b0};
      end else begin
        eff_addr = {page_regs[{1'b0, dma_channel_in}], addr_in[15:0]}; // [R15]
      end
    end
  end

  // Memory target decode; areas not listed fall to tgt_none for the slot
  addr_decode_pkg::mem_target_t next_target;
  always_comb begin
    next_target = addr_decode_pkg::tgt_none; // [R17] [R08] [R10] [R11]
    if (eff_addr <= `BASE_RAM_TOP) begin
      if (!(upper_off && eff_addr >= `BASE_RAM_STRAP_LO)) begin // [R02]
        next_target = addr_decode_pkg::tgt_base_ram; // [R01]
      end
    end else if (colour && eff_addr >= `CGA_VRAM_LO && eff_addr <= `CGA_VRAM_HI) begin
      next_target = addr_decode_pkg::tgt_vram; // [R06] [R05]
    end else if (!colour && eff_addr >= `MONO_VRAM_LO && eff_addr <= `MONO_VRAM_HI) begin
      next_target = addr_decode_pkg::tgt_vram; // [R07] [R05]
    end else if (eff_addr[23:16] == 8'(`BIOS_LOW_LO >> 16)
      || eff_addr[23:16] == 8'(`BIOS_HIGH_LO >> 16)) begin
      next_target = addr_decode_pkg::tgt_bios; // [R04]
    end else if (exp_fitted && eff_addr >= `EXP_RAM_LO && eff_addr <= `EXP_RAM_HI) begin
      next_target = addr_decode_pkg::tgt_exp_ram; // [R09]
    end
  end

  // Memory selects registered; master keeps address stable meanwhile [R18]
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      base_ram_sel_out <= 1'b0;
      exp_ram_sel_out <= 1'b0;
      vram_sel_out <= 1'b0;
      bios_sel_out <= 1'b0;
      phys_addr_out <= 24'h000000;
    end else begin
      base_ram_sel_out <= cycle_valid_in && mem_cycle_in
        && next_target == addr_decode_pkg::tgt_base_ram;
      exp_ram_sel_out <= cycle_valid_in && mem_cycle_in
        && next_target == addr_decode_pkg::tgt_exp_ram;
      vram_sel_out <= cycle_valid_in && mem_cycle_in
        && next_target == addr_decode_pkg::tgt_vram;
      bios_sel_out <= cycle_valid_in && mem_cycle_in
        && next_target == addr_decode_pkg::tgt_bios; // Same ROM both images
      phys_addr_out <= eff_addr;
    end
  end

  // I/O decode, 16-bit port space, byte lanes from A0 and high enable
  logic io_cyc;
  logic ser_hit;
  logic xfer1_hit;
  logic xfer2_hit;
  logic coproc_hit;
  assign io_cyc = cycle_valid_in && !mem_cycle_in && !dma_cycle_in;
  // Both serial groups alias the divisor latch the same way
  assign ser_hit = addr_in[15:1] == 15'(`IO_SERIAL1_BASE >> 1)
    || addr_in[15:1] == 15'(`IO_SERIAL2_BASE >> 1);
  // First controller owns 16 byte ports, second a 32-port word-spaced block
  assign xfer1_hit = addr_in[15:4] == 12'(`IO_XFER1_PAT >> 4);
  assign xfer2_hit = addr_in[15:5] == 11'(`IO_XFER2_PAT >> 5);
  // Coprocessor data ports, eight bytes from its base
  assign coproc_hit = addr_in[15:3] == 13'(`IO_COPROC_LO >> 3);
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      io_low_sel_out <= 1'b0;
      io_high_sel_out <= 1'b0;
      xfer1_sel_out <= 1'b0;
      xfer2_sel_out <= 1'b0;
      xfer_reg_out <= 4'h0;
      page_sel_out <= 1'b0;
      ser_data_sel_out <= 1'b0;
      ser_ier_sel_out <= 1'b0;
      ser_div_lo_sel_out <= 1'b0;
      ser_div_hi_sel_out <= 1'b0;
      coproc_sel_out <= 1'b0;
      coproc_busy_clear_out <= 1'b0;
      coproc_reset_out <= 1'b0;
    end else begin
      io_low_sel_out <= io_cyc && !addr_in[0]; // [R12]
      io_high_sel_out <= io_cyc && (addr_in[0] || !byte_high_n_in); // [R12]
      xfer1_sel_out <= io_cyc && xfer1_hit; // [R16]
      xfer2_sel_out <= io_cyc && xfer2_hit && !addr_in[0]; // [R16] even only
      xfer_reg_out <= xfer2_hit ? addr_in[4:1] : addr_in[3:0]; // [R16]
      page_sel_out <= page_access;
      ser_data_sel_out <= io_cyc && ser_hit && !addr_in[0] && !dlab; // [R13]
      ser_ier_sel_out <= io_cyc && ser_hit && addr_in[0] && !dlab; // [R13]
      ser_div_lo_sel_out <= io_cyc && ser_hit && !addr_in[0] && dlab; // [R13]
      ser_div_hi_sel_out <= io_cyc && ser_hit && addr_in[0] && dlab; // [R13]
      coproc_sel_out <= io_cyc && coproc_hit;
      coproc_busy_clear_out <= io_cyc && write_in && addr_in[15:0] == `IO_COPROC_BUSY; // [R14]
      coproc_reset_out <= io_cyc && write_in && addr_in[15:0] == `IO_COPROC_RESET; // [R14]
    end
  end

  // Checks
  // Named request steps; the video, low BIOS, expansion RAM fitted and base RAM top properties start from one of these
  sequence s_mem_req;
    cycle_valid_in && mem_cycle_in;
  endsequence

  // Colour window hit while the colour switch is on
  sequence s_colour_hit;
    cycle_valid_in && mem_cycle_in && colour
      && eff_addr >= `CGA_VRAM_LO && eff_addr <= `CGA_VRAM_HI;
  endsequence

  // Monochrome window hit while the colour switch is off
  sequence s_mono_hit;
    cycle_valid_in && mem_cycle_in && !colour
      && eff_addr >= `MONO_VRAM_LO && eff_addr <= `MONO_VRAM_HI;
  endsequence

  // Monochrome window asked for while colour is chosen: must stay dark
  sequence s_mono_idle;
    cycle_valid_in && mem_cycle_in && colour
      && eff_addr >= `MONO_VRAM_LO && eff_addr <= `MONO_VRAM_HI;
  endsequence

  // Low BIOS image in the first megabyte
  sequence s_low_bios;
    cycle_valid_in && mem_cycle_in && eff_addr[23:16] == 8'h0f;
  endsequence

  // Second megabyte while the expansion RAM is fitted
  sequence s_exp_hit;
    cycle_valid_in && mem_cycle_in && exp_fitted
      && eff_addr >= `EXP_RAM_LO && eff_addr <= `EXP_RAM_HI;
  endsequence

  // I/O write to the coprocessor reset port
  sequence s_coproc_rst;
    io_cyc && write_in && addr_in[15:0] == `IO_COPROC_RESET;
  endsequence

  // Serial offset zero with the latch bit clear
  sequence s_ser_data;
    io_cyc && ser_hit && !addr_in[0] && !dlab;
  endsequence

  a_one_mem_sel: assert property (@(posedge clk_in) disable iff (reset_in) // [R05]
    $onehot0({base_ram_sel_out, exp_ram_sel_out, vram_sel_out, bios_sel_out}))
    else $error("more than one memory select");
  a_base_ram_sel: assert property (@(posedge clk_in) disable iff (reset_in) // [R01]
    cycle_valid_in && mem_cycle_in && !dma_cycle_in && protected_mode_in
    && addr_in < `BASE_RAM_STRAP_LO |=> base_ram_sel_out)
    else $error("base ram not selected");
  a_strap_off: assert property (@(posedge clk_in) disable iff (reset_in) // [R02]
    upper_off && eff_addr >= `BASE_RAM_STRAP_LO |=> !base_ram_sel_out)
    else $error("strapped ram selected");
  a_exp_rom_free: assert property (@(posedge clk_in) disable iff (reset_in) // [R08]
    eff_addr[23:16] == 8'h0e |=> !(base_ram_sel_out || bios_sel_out || exp_ram_sel_out))
    else $error("expansion rom area selected");
  a_high_bios: assert property (@(posedge clk_in) disable iff (reset_in) // [R04]
    cycle_valid_in && mem_cycle_in && eff_addr[23:16] == 8'hff |=> bios_sel_out)
    else $error("top bios not selected");
  a_slot_ram_free: assert property (@(posedge clk_in) disable iff (reset_in) // [R11]
    eff_addr[23:16] == 8'hfe || eff_addr[23:21] != 3'h0 && eff_addr[23:16] < 8'hfe
    |=> !bios_sel_out && !base_ram_sel_out && !exp_ram_sel_out && !vram_sel_out)
    else $error("slot area selected");
  a_coproc_clear: assert property (@(posedge clk_in) disable iff (reset_in) // [R14]
    io_cyc && write_in && addr_in[15:0] == `IO_COPROC_BUSY |=> coproc_busy_clear_out
    && !coproc_reset_out)
    else $error("busy clear missing");
  a_serial_steer: assert property (@(posedge clk_in) disable iff (reset_in) // [R13]
    ser_div_lo_sel_out |-> !ser_data_sel_out && $past(dlab))
    else $error("divisor latch steering wrong");

  // Video windows follow the display switch, never both at once
  a_colour_vram: assert property (@(posedge clk_in) disable iff (reset_in) // [R06]
    s_colour_hit |=> vram_sel_out)
    else $error("colour window not selected");
  a_mono_vram: assert property (@(posedge clk_in) disable iff (reset_in) // [R07]
    s_mono_hit |=> vram_sel_out)
    else $error("monochrome window not selected");
  a_one_window: assert property (@(posedge clk_in) disable iff (reset_in) // [R05]
    s_mono_idle |=> !vram_sel_out)
    else $error("second video window selected");

  // Both BIOS images select the same ROM
  a_low_bios: assert property (@(posedge clk_in) disable iff (reset_in) // [R04]
    s_low_bios |=> bios_sel_out)
    else $error("low bios not selected");

  // Expansion RAM answers only when the strap says it is fitted
  a_exp_ram_on: assert property (@(posedge clk_in) disable iff (reset_in) // [R09]
    s_exp_hit |=> exp_ram_sel_out)
    else $error("expansion ram not selected");
  a_exp_ram_off: assert property (@(posedge clk_in) disable iff (reset_in) // [R09]
    !exp_fitted |=> !exp_ram_sel_out)
    else $error("absent expansion ram selected");

  // Real mode drops the top four lines; transfers bypass the mask
  a_real_mask: assert property (@(posedge clk_in) disable iff (reset_in) // [R03]
    !protected_mode_in && !dma_cycle_in |=> phys_addr_out[23:20] == 4'h0)
    else $error("real mode address not masked");

  // Word channels always land on an even byte address
  a_word_xfer: assert property (@(posedge clk_in) disable iff (reset_in) // [R15]
    dma_cycle_in && dma_second_in |=> !phys_addr_out[0])
    else $error("word transfer address odd");

  // Byte lanes: even port on the low lane, odd port on the high lane only
  a_io_even: assert property (@(posedge clk_in) disable iff (reset_in) // [R12]
    io_cyc && !addr_in[0] |=> io_low_sel_out)
    else $error("low lane missing");
  a_io_odd: assert property (@(posedge clk_in) disable iff (reset_in) // [R12]
    io_cyc && addr_in[0] |=> io_high_sel_out && !io_low_sel_out)
    else $error("odd port lane wrong");

  // Second controller is word-spaced, so odd ports must not reach it
  a_xfer2_even: assert property (@(posedge clk_in) disable iff (reset_in) // [R16]
    xfer2_sel_out |-> !$past(addr_in[0]))
    else $error("odd port hit second controller");

  // Transfer cycles reuse the address bus, so no port may decode then
  a_dma_no_io: assert property (@(posedge clk_in) disable iff (reset_in) // [R17]
    cycle_valid_in && dma_cycle_in
    |=> !(io_low_sel_out || io_high_sel_out || page_sel_out || coproc_sel_out))
    else $error("port selected in transfer cycle");

  // Idle bus leaves every select low so the slot may own the cycle
  a_idle_quiet: assert property (@(posedge clk_in) disable iff (reset_in) // [R17]
    !cycle_valid_in |=> !(base_ram_sel_out || exp_ram_sel_out || vram_sel_out
    || bios_sel_out || io_low_sel_out || io_high_sel_out))
    else $error("select with no cycle");

  // Coprocessor reset port strobes reset and the high byte lane, not busy clear
  a_coproc_reset: assert property (@(posedge clk_in) disable iff (reset_in) // [R14]
    s_coproc_rst |=> coproc_reset_out && !coproc_busy_clear_out)
    else $error("coprocessor reset missing");

  // Latch bit clear: offset zero reaches the data buffer, not the divisor
  a_serial_data: assert property (@(posedge clk_in) disable iff (reset_in) // [R13]
    s_ser_data |=> ser_data_sel_out && !ser_div_lo_sel_out)
    else $error("data buffer not selected");

  // Base RAM is never chosen above its top, whatever the straps say
  a_base_ram_top: assert property (@(posedge clk_in) disable iff (reset_in) // [R01]
    s_mem_req ##0 eff_addr > `BASE_RAM_TOP |=> !base_ram_sel_out)
    else $error("base ram above its top");

endmodule // system_address_decoder

// ===== hdl/addr_decode_map.svh
// Address map constants for the system address decoder.
// Assumes 24-bit memory addresses and 16-bit I/O addresses from one bus master.
// Function
// R01 - Base RAM selected from zero to 09ffff
// R02 - Strap disables base RAM 080000 to 09ffff
// R03 - Real mode twenty lines, protected twenty-four
// R04 - BIOS ROM at 0f0000 and ff0000
// R05 - Exactly one video window by switch
// R06 - Colour mode maps video at 0b8000-0bbfff
// R07 - Monochrome mode maps video at 0b0000
// R08 - Never select board memory 0e0000-0effff
// R09 - Expansion RAM at 100000 when fitted
// R10 - Leave 200000-fdefff unselected for slot
// R11 - Leave fe0000-feffff for slot RAM
// R12 - Byte ports, adjacent pairs as word
// R13 - Divisor latch bit steers serial offsets
// R14 - Coprocessor ports clear busy, reset
// R15 - Page registers extend transfer addresses
// R16 - Two transfer controllers, second word-spaced
// R17 - Unmapped addresses give no chip select
// R18 - Master holds address stable before sampling
`ifndef ADDR_DECODE_MAP_SVH
`define ADDR_DECODE_MAP_SVH
`define BASE_RAM_TOP 24'h09ffff
`define BASE_RAM_STRAP_LO 24'h080000
`define MONO_VRAM_LO 24'h0b0000
`define MONO_VRAM_HI 24'h0b0fff
`define CGA_VRAM_LO 24'h0b8000
`define CGA_VRAM_HI 24'h0bbfff
`define BIOS_LOW_LO 24'h0f0000
`define BIOS_HIGH_LO 24'hff0000
`define EXP_RAM_LO 24'h100000
`define EXP_RAM_HI 24'h1fffff
`define REAL_MASK 24'h0fffff
`define IO_XFER1_PAT 16'h0000
`define IO_XFER2_PAT 16'h00c0
`define IO_PAGE_PAT 16'h0080
`define IO_COPROC_BUSY 16'h00f0
`define IO_COPROC_RESET 16'h00f1
`define IO_COPROC_LO 16'h00f8
`define IO_SERIAL1_BASE 16'h03f8
`define IO_SERIAL2_BASE 16'h02f8
`endif

// ===== hdl/addr_decode_pkg.sv
// Types shared by the system address decoder.
// Assumes the constants header supplies every address figure.
package addr_decode_pkg;
  typedef enum logic [2:0] {
    tgt_none = 3'b000,
    tgt_base_ram = 3'b001,
    tgt_exp_ram = 3'b010,
    tgt_vram = 3'b011,
    tgt_bios = 3'b100
  } mem_target_t;
endpackage

// ===== tb/bus_master_model.sv
// Bus master model that issues CPU and transfer-controller cycles to the decoder.
// Assumes the decoder samples its inputs on every rising edge of clk_in.
`timescale 1ns/1ps
module bus_master_model (
  input wire logic clk_in,
  output logic valid_out,
  output logic mem_out,
  output logic write_out,
  output logic [23:0] addr_out,
  output logic bhe_n_out,
  output logic [7:0] data_out,
  output logic dma_out,
  output logic second_out,
  output logic [1:0] channel_out
);
  // Bus starts idle
  initial begin
    {valid_out, mem_out, write_out, bhe_n_out, dma_out, second_out} = 6'h00;
    addr_out = 24'h000000;
    data_out = 8'h00;
    channel_out = 2'h0;
  end
  // One cycle: set after a falling edge, held across the sampling edge
  task automatic run(input logic [4:0] c, input logic [23:0] a, input logic [7:0] d,
                     input logic [1:0] ch);
    @(negedge clk_in);
    valid_out = 1'b1;
    {mem_out, write_out, bhe_n_out, dma_out, second_out} = c;
    addr_out = a;
    data_out = d;
    channel_out = ch;
    @(negedge clk_in);
    // Released bus shows inverted stale values so a stuck copy cannot pass
    {valid_out, write_out, dma_out} = 3'h0;
    addr_out = ~a;
    data_out = ~d;
  endtask
endmodule // bus_master_model

// ===== tb/test_system_address_decoder.sv
// Self-checking bench for the system address decoder.
// Assumes the bus master model drives every bus input of the decoder.
`timescale 1ns/1ps
module test_system_address_decoder;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic strap = 1'b0;
  logic colour = 1'b1;
  logic fitted = 1'b1;
  logic prot = 1'b1;
  logic dl = 1'b0;
  logic cv, mc, wr, bhn, dma, sec, csel;
  logic [1:0] ch;
  logic [7:0] data;
  logic [23:0] addr, phys;
  logic [3:0] mem_sel, xreg;
  logic [10:0] io_sel;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  // Address, then expected {base, expansion, video, bios}
  logic [27:0] map_a[19] = '{28'h0000008, 28'h09ffff8, 28'h0a00000, 28'h0e00000,
    28'h0efff00, 28'h0f00001, 28'h0fffff1, 28'hff00001, 28'hffffff1, 28'h1000004,
    28'h1fffff4, 28'h2000000, 28'hfdefff0, 28'hfe00000, 28'hfeffff0, 28'h0b80002,
    28'h0bbfff2, 28'h0bc0000, 28'h0b00000};
  logic [27:0] map_b[7] = '{28'h07ffff8, 28'h0800000, 28'h09ffff0, 28'h0b00002,
    28'h0b0fff2, 28'h0b80000, 28'h1000000};
  logic [27:0] map_c[4] = '{28'h1000008, 28'h1f00001, 28'hff00001, 28'hfe00000};
  // Port, {write, high byte off, latch bit, 0}, expected selects
  logic [31:0] io_t[14] = '{32'h00f0c402, 32'h00f04400, 32'h00f1c201, 32'h03f84420,
    32'h03f86408, 32'h03f94210, 32'h03f96204, 32'h02f94210, 32'h00600600,
    32'h00004500, 32'h00c04480, 32'h00c14200, 32'h0087c240, 32'h12344400};

  bus_master_model bus_master_model_inst (.clk_in(clk_in), .valid_out(cv), .mem_out(mc),
    .write_out(wr), .addr_out(addr), .bhe_n_out(bhn), .data_out(data), .dma_out(dma),
    .second_out(sec), .channel_out(ch));

  system_address_decoder system_address_decoder_inst (.clk_in(clk_in), .reset_in(reset_in),
    .cycle_valid_in(cv), .mem_cycle_in(mc), .write_in(wr), .addr_in(addr),
    .byte_high_n_in(bhn), .protected_mode_in(prot), .dma_cycle_in(dma),
    .dma_second_in(sec), .dma_channel_in(ch), .data_in(data), .strap_upper_ram_in(strap),
    .colour_mode_in(colour), .exp_ram_fitted_in(fitted), .divisor_latch_in(dl),
    .base_ram_sel_out(mem_sel[3]), .exp_ram_sel_out(mem_sel[2]), .vram_sel_out(mem_sel[1]),
    .bios_sel_out(mem_sel[0]), .phys_addr_out(phys), .io_low_sel_out(io_sel[10]),
    .io_high_sel_out(io_sel[9]), .xfer1_sel_out(io_sel[8]), .xfer2_sel_out(io_sel[7]),
    .xfer_reg_out(xreg), .page_sel_out(io_sel[6]), .ser_data_sel_out(io_sel[5]),
    .ser_ier_sel_out(io_sel[4]), .ser_div_lo_sel_out(io_sel[3]),
    .ser_div_hi_sel_out(io_sel[2]), .coproc_sel_out(csel),
    .coproc_busy_clear_out(io_sel[1]), .coproc_reset_out(io_sel[0]));

  always #25 clk_in = ~clk_in;

  // Cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Straps pass two sync flops, so allow three cycles to settle
  task automatic cfg(input logic [4:0] v);
    @(negedge clk_in);
    {strap, colour, fitted, prot, dl} = v;
    repeat (3) @(negedge clk_in);
  endtask

  task automatic mem_chk(input logic [27:0] e);
    bus_master_model_inst.run(5'b10100, e[27:4], 8'h00, 2'h0);
    chk({20'h0, mem_sel}, {20'h0, e[3:0]});
  endtask

  task automatic io_chk(input logic [31:0] e);
    cfg({strap, colour, fitted, prot, e[13]});
    bus_master_model_inst.run({1'b0, e[15:14], 2'b00}, {8'h00, e[31:16]}, 8'h00, 2'h0);
    chk({13'h0, io_sel}, {13'h0, e[10:0]});
  endtask

  task automatic t_mem();
    cfg(5'b01110);
    foreach (map_a[i]) mem_chk(map_a[i]);
    cfg(5'b10010);
    foreach (map_b[i]) mem_chk(map_b[i]);
    cfg(5'b01100);
    foreach (map_c[i]) mem_chk(map_c[i]);
  endtask

  task automatic t_io();
    cfg(5'b01110);
    foreach (io_t[i]) io_chk(io_t[i]);
    bus_master_model_inst.run(5'b00100, 24'h0000c6, 8'h00, 2'h0);
    chk({20'h0, xreg}, 24'h000003);
    bus_master_model_inst.run(5'b00100, 24'h00000b, 8'h00, 2'h0);
    chk({20'h0, xreg}, 24'h00000b);
    bus_master_model_inst.run(5'b00100, 24'h0000f8, 8'h00, 2'h0);
    chk({23'h0, csel}, 24'h000001);
    bus_master_model_inst.run(5'b00100, 24'h0000f0, 8'h00, 2'h0);
    chk({23'h0, csel}, 24'h000000);
  endtask

  // Page register supplies the upper bits; second controller works in words
  task automatic t_dma();
    bus_master_model_inst.run(5'b01100, 24'h000087, 8'h12, 2'h0);
    bus_master_model_inst.run(5'b10110, 24'h003456, 8'h00, 2'h0);
    chk(phys, 24'h123456);
    chk({13'h0, io_sel}, 24'h000000);
    bus_master_model_inst.run(5'b01100, 24'h00008b, 8'h24, 2'h0);
    bus_master_model_inst.run(5'b10111, 24'h001234, 8'h00, 2'h1);
    chk(phys, 24'h242468);
  endtask

  initial begin
    repeat (5) @(negedge clk_in);
    reset_in = 1'b0;
    t_mem();
    t_io();
    t_dma();
    test_done();
  end
endmodule // test_system_address_decoder
